// ===== bench/apr_pin_router_assertions.sv
// Port-level assertions for the alternate pin router
`timescale 1ns/1ps
module apr_pin_router_assertions (
    input wire clk_sys,
    input wire reset_n,
    input wire [7:0] sfrAddr,
    input wire [3:0] sfrPage,
    input wire sfrWr,
    input wire sfrRd,
    input wire [7:0] sfrWrData,
    input wire [7:0] sfrRdData,
    input wire [55:0] pinIn,
    input wire [55:0] pinOut,
    input wire [55:0] pinOe,
    input wire tmr1In,
    input wire tmr2ClkIn,
    input wire tmr2ExIn,
    input wire cmp0Result,
    input wire cmp1Result,
    input wire baudAOe,
    input wire baudBOe,
    input wire [5:0] pwmModOe,
    input wire pwmtmrOvf
);
    localparam int T1P[4] = '{29, 37, 15, 27};
    localparam int T2C[4] = '{8, 26, 48, 37};
    localparam int T2E[4] = '{9, 27, 29, 36};
    reg [7:0] shP1;
    reg [7:0] shP2;
    reg [7:0] shP4;
    // ----
    // Shadow copies of the routing registers on pages 1, 2 and 4
    // ----
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            shP1 <= 8'h00;
            shP2 <= 8'h00;
            shP4 <= 8'h00;
        end else if (sfrWr && sfrAddr == 8'ha4) begin
            if (sfrPage == 4'h1) shP1 <= sfrWrData;
            if (sfrPage == 4'h2) shP2 <= sfrWrData;
            if (sfrPage == 4'h4) shP4 <= sfrWrData;
        end
    end
    // ----
    // Assertions
    // ----
    default clocking dc @(posedge clk_sys);
    endclocking
    default disable iff (!reset_n);
    sequence s_wr_p1;
        sfrWr && sfrAddr == 8'ha4 && sfrPage == 4'h1;
    endsequence
    sequence s_rd_p1;
        sfrRd && !sfrWr && sfrAddr == 8'ha4 && sfrPage == 4'h1;
    endsequence
    a_rd_unmapped: assert property (sfrRd && !(sfrAddr inside {8'ha4, 8'hc1}) |=> sfrRdData == 8'h00)
        else $error("unmapped read not zero");
    a_rd_hole: assert property (sfrRd && sfrAddr == 8'ha4 && sfrPage inside {4'ha, 4'hb, 4'hc, 4'hf}
        |=> sfrRdData == 8'h00) else $error("unused page read not zero");
    a_rd_readback: assert property (s_wr_p1 ##1 !sfrWr ##1 s_rd_p1 |=> sfrRdData == $past(sfrWrData, 3))
        else $error("register read back differs");
    a_rd_holds: assert property (!sfrRd |=> $stable(sfrRdData))
        else $error("read data changed without read");
    a_tmr1_route: assert property (tmr1In == pinIn[T1P[shP1[5:4]]])
        else $error("timer 1 input from wrong pin");
    a_tmr2_route: assert property (tmr2ClkIn == pinIn[T2C[shP1[7:6]]] && tmr2ExIn == pinIn[T2E[shP1[7:6]]])
        else $error("timer 2 inputs from wrong pins");
    a_cmp1_drive: assert property (shP1[3] && !pwmModOe[3] |-> pinOe[5] && pinOut[5] == cmp1Result)
        else $error("comparator 1 not on its pin");
    a_cmp0_drive: assert property (shP1[1] && !baudBOe |-> pinOe[37] && pinOut[37] == cmp0Result)
        else $error("comparator 0 not on its pin");
    a_clkout_toggle: assert property (shP4[5] && !shP4[4] && !shP2[0] && !baudAOe && !baudBOe && pwmtmrOvf
        |=> pinOe[39] && $changed(pinOut[39])) else $error("clock output did not toggle");
    a_clkout_quiet: assert property (!shP4[5] && !shP4[4] && !baudAOe && !baudBOe |-> !pinOe[39])
        else $error("clock output pin driven while off");
endmodule
bind apr_pin_router apr_pin_router_assertions apr_pin_router_assertions_i (
    .clk_sys(clk_sys), .reset_n(reset_n), .sfrAddr(sfrAddr), .sfrPage(sfrPage), .sfrWr(sfrWr), .sfrRd(sfrRd),
    .sfrWrData(sfrWrData), .sfrRdData(sfrRdData), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe),
    .tmr1In(tmr1In), .tmr2ClkIn(tmr2ClkIn), .tmr2ExIn(tmr2ExIn), .cmp0Result(cmp0Result),
    .cmp1Result(cmp1Result), .baudAOe(baudAOe), .baudBOe(baudBOe), .pwmModOe(pwmModOe), .pwmtmrOvf(pwmtmrOvf)
);

// ===== bench/apr_pin_router_test.sv
// Self-checking bench for the alternate pin router
`timescale 1ns/1ps
module apr_pin_router_test;
    logic clk_sys = 1'h0, reset_n = 1'h0, sfrWr = 1'h0, sfrRd = 1'h0, sysClkIsRc = 1'h0, mainClock = 1'h0;
    logic lowSpeedTick = 1'h0, pwmtmrOvf = 1'h0, arrayOvf = 1'h0, uartATx = 1'h0, uartATxOe = 1'h0;
    logic uartBTx = 1'h0, uartBTxOe = 1'h0, twaSclLow = 1'h0, twaSdaLow = 1'h0, twbSclLow = 1'h0, twbSdaLow = 1'h0;
    logic tmr1Cko = 1'h0, tmr1CkoOe = 1'h0, tmr2Cko = 1'h0, tmr2CkoOe = 1'h0, tmr3Cko = 1'h0, tmr3CkoOe = 1'h0;
    logic cmp0Result = 1'h0, cmp1Result = 1'h0, baudAClk = 1'h0, baudAOe = 1'h0, baudBClk = 1'h0, baudBOe = 1'h0;
    logic [7:0] sfrAddr = 8'h00, sfrWrData = 8'h00;
    logic [3:0] sfrPage = 4'h0, spiOut = 4'h0, spiOe = 4'h0;
    logic [55:0] pinIn = 56'h0;
    logic [1:0] pwmCh2Out = 2'h0, pwmCh0Out = 2'h0, pwmPairOe = 2'h0, arrayModOut = 2'h0, arrayModOe = 2'h0;
    logic [5:0] pwmModOut = 6'h0, pwmModOe = 6'h0;
    logic [7:0] sfrRdData, keypad;
    logic [55:0] pinOut, pinOe;
    logic [3:0] spiIn;
    logic [5:0] pwmModIn;
    logic [1:0] arrayModIn, captureIn;
    logic pin60FastDrive, uartARx, uartBRx, twaSclIn, twaSdaIn, twbSclIn, twbSdaIn, tmr1In, tmr2ClkIn, tmr2ExIn;
    logic tmr3ClkIn, tmr3ExIn, masterIn0, masterIn1, pwmtmrExtClk, arrayExtClk, irq0In, irq1In, debugSclIn, debugSdaIn;
    int fails = 0, total_checks = 0, cyc = 0, sel = 0, pIdx = 0, cnt = 0, lvl = 0;
    logic chk = 1'h0;
    logic [7:0] obs, expV;
    logic [7:0] expQ[$];
    localparam int PG[14] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 13, 14, 0, 1};
    localparam logic [7:0] MSK[14] = '{8'hff, 8'hfa, 8'h3f, 8'hf3, 8'h30, 8'h67, 8'hf3, 8'h3f, 8'h3b, 8'hfc,
        8'h3f, 8'h03, 8'hff, 8'hff};
    localparam int T1P[4] = '{29, 37, 15, 27};
    localparam int T2C[4] = '{8, 26, 48, 37};
    localparam int I1P[8] = '{27, 25, 29, 33, 37, 13, 8, 7};
    localparam int I0P[8] = '{26, 24, 28, 32, 8, 12, 15, 5};
    localparam int URX[4] = '{24, 36, 25, 15};
    localparam int UTX[4] = '{25, 37, 24, 18};
    localparam int SS[4] = '{12, 1, 27, 15};
    localparam int MO[4] = '{13, 2, 13, 29};
    localparam int MI[4] = '{14, 33, 14, 28};
    localparam int SCK[4] = '{15, 32, 15, 27};

    always #5 clk_sys = ~clk_sys;

    apr_pin_router apr_pin_router_i (.*);

    // ----
    // Output watcher
    // ----
    always_comb begin
        case (sel)
            0: obs = sfrRdData;
            1: obs = {7'h0, pinOut[pIdx]};
            2: obs = {7'h0, pinOe[pIdx]};
            3: obs = {7'h0, tmr1In};
            4: obs = {7'h0, irq1In};
            5: obs = {7'h0, uartARx};
            6: obs = {4'h0, spiIn};
            7: obs = {7'h0, uartBRx};
            9: obs = {pwmtmrExtClk, arrayExtClk, captureIn, debugSclIn, debugSdaIn, masterIn1, masterIn0};
            10: obs = keypad;
            default: obs = {7'h0, irq0In};
        endcase
    end

    always @(posedge clk_sys) begin
        cyc = cyc + 1;
        if (chk) begin
            expV = expQ.pop_front();
            total_checks++;
            if (obs !== expV) begin
                fails++;
                $display("Error %0t: sel %0d pin %0d got %h expected %h", $time, sel, pIdx, obs, expV);
            end
        end
        if (cyc == 20000) begin
            fails++;
            $display("Error %0t: timeout", $time);
            end_sim();
        end
    end

    task end_sim;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task ck(input int s, input int p, input logic [7:0] e);
        sel = s;
        pIdx = p;
        expQ.push_back(e);
        chk = 1'h1;
        @(posedge clk_sys);
        #1 chk = 1'h0;
        @(negedge clk_sys);
    endtask

    task wr(input logic [7:0] a, input logic [3:0] p, input logic [7:0] d);
        @(negedge clk_sys);
        sfrAddr = a;
        sfrPage = p;
        sfrWrData = d;
        sfrWr = 1'h1;
        @(negedge clk_sys);
        sfrWr = 1'h0;
    endtask

    task rd(input logic [7:0] a, input logic [3:0] p, input logic [7:0] e);
        @(negedge clk_sys);
        sfrAddr = a;
        sfrPage = p;
        sfrRd = 1'h1;
        @(negedge clk_sys);
        sfrRd = 1'h0;
        ck(0, 0, e);
    endtask

    task stir;
        pinIn = 56'({$urandom(), $urandom()});
        {uartATx, tmr1Cko, tmr2Cko, cmp0Result, cmp1Result} = 5'($urandom());
        spiOut = 4'($urandom());
    endtask

    // ----
    // Main sequence
    // ----
    initial begin
        int i, c, n;
        logic [7:0] d;
        void'($urandom(32'h4ef6822d));
        repeat (3) @(negedge clk_sys);
        reset_n = 1'h1;
        for (i = 0; i < 14; i++) rd(i < 12 ? 8'ha4 : 8'hc1, 4'(PG[i]), 8'h00);
        for (i = 0; i < 14; i++) begin
            d = 8'($urandom()) & MSK[i];
            wr(i < 12 ? 8'ha4 : 8'hc1, 4'(PG[i]), d);
            rd(i < 12 ? 8'ha4 : 8'hc1, 4'(PG[i]), d);
            wr(i < 12 ? 8'ha4 : 8'hc1, 4'(PG[i]), 8'h00);
        end
        wr(8'ha4, 4'ha, 8'hff);
        rd(8'ha4, 4'ha, 8'h00);
        rd(8'h55, 4'h0, 8'h00);
        tmr1CkoOe = 1'h1;
        tmr2CkoOe = 1'h1;
        for (c = 0; c < 4; c++) begin
            wr(8'ha4, 4'h1, 8'(c * 80));
            stir();
            ck(1, T1P[c], tmr1Cko);
            ck(2, T1P[c], 8'h01);
            ck(3, 0, pinIn[T1P[c]]);
            ck(1, T2C[c], tmr2Cko);
        end
        tmr1CkoOe = 1'h0;
        tmr2CkoOe = 1'h0;
        for (c = 0; c < 8; c++) begin
            wr(8'hc1, 4'h0, 8'(c % 4 * 80));
            wr(8'hc1, 4'h1, 8'(c / 4 * 192));
            stir();
            ck(4, 0, pinIn[I1P[c]]);
            ck(8, 0, pinIn[I0P[c]]);
        end
        uartATxOe = 1'h1;
        for (c = 0; c < 4; c++) begin
            wr(8'ha4, 4'h0, 8'(c % 2 * 8));
            wr(8'ha4, 4'h7, 8'(c / 2 * 8));
            stir();
            ck(5, 0, pinIn[URX[c]]);
            ck(1, UTX[c], uartATx);
        end
        uartATxOe = 1'h0;
        spiOe = 4'hb;
        for (c = 0; c < 4; c++) begin
            wr(8'ha4, 4'h7, 8'(c * 16));
            stir();
            ck(6, 0, {4'h0, pinIn[SCK[c]], pinIn[MI[c]], pinIn[MO[c]], pinIn[SS[c]]});
            ck(1, SCK[c], spiOut[3]);
            ck(1, MO[c], spiOut[1]);
        end
        spiOe = 4'h0;
        wr(8'ha4, 4'h1, 8'h0a);
        stir();
        ck(1, 5, cmp1Result);
        ck(1, 37, cmp0Result);
        wr(8'ha4, 4'h1, 8'h00);
        ck(2, 5, 8'h00);
        ck(2, 37, 8'h00);
        wr(8'ha4, 4'h8, 8'h08);
        ck(7, 0, cmp0Result);
        wr(8'ha4, 4'h8, 8'h00);
        ck(7, 0, pinIn[10]);
        wr(8'ha4, 4'h4, 8'h20);
        for (i = 0; i < 5; i++) begin
            @(negedge clk_sys);
            pwmtmrOvf = 1'h1;
            @(negedge clk_sys);
            pwmtmrOvf = 1'h0;
            lvl = 1 - lvl;
            ck(1, 39, 8'(lvl));
        end
        wr(8'ha4, 4'h2, 8'h01);
        ck(1, 27, 8'(lvl));
        ck(2, 39, 8'h00);
        wr(8'ha4, 4'h4, 8'h00);
        ck(2, 27, 8'h00);
        wr(8'ha4, 4'h2, 8'h00);
        ck(9, 0, {{2{pinIn[2]}}, pinIn[49], pinIn[48], pinIn[7], pinIn[14], pinIn[8], pinIn[14]});
        ck(10, 0, pinIn[15:8]);
        wr(8'ha4, 4'h2, 8'h0a);
        wr(8'ha4, 4'h3, 8'hf2);
        wr(8'ha4, 4'h5, 8'h60);
        wr(8'ha4, 4'h6, 8'hc0);
        ck(9, 0, {pinIn[14], pinIn[13], {2{pinIn[9], pinIn[28]}}, pinIn[29], pinIn[27]});
        ck(10, 0, {pinIn[15:14], pinIn[49:48], pinIn[37:36], pinIn[33:32]});
        sysClkIsRc = 1'h1;
        mainClock = 1'h1;
        wr(8'ha4, 4'h7, 8'h02);
        ck(1, 48, 8'h01);
        for (c = 1; c < 4; c++) begin
            wr(8'ha4, 4'h0, 8'(c * 16));
            repeat (3) begin
                n = $urandom_range(40, 1);
                repeat (n) begin
                    @(negedge clk_sys);
                    lowSpeedTick = 1'h1;
                    @(negedge clk_sys);
                    lowSpeedTick = 1'h0;
                end
                cnt = cnt + n;
                ck(1, 36, 8'(cnt >> (5 - c) & 1));
            end
            ck(2, 36, 8'h01);
        end
        wr(8'ha4, 4'h0, 8'h00);
        ck(2, 36, 8'h00);
        end_sim();
    end
endmodule

// ===== common/apr_defs.vh
// Addresses, pages, field positions and reset values of the pin router
`ifndef APR_DEFS_VH
`define APR_DEFS_VH
`define APR_P(p, b) {3'h p, 3'h b}
`define APR_ADDR_AUX 8'ha4
`define APR_ADDR_IRQ 8'hc1
`define APR_AUX_PAGES 16'h63ff
`define APR_RST 8'h00
`define APR_PG_R3 4'h0
`define APR_PG_R4 4'h1
`define APR_PG_R5 4'h2
`define APR_PG_R6 4'h3
`define APR_PG_R7 4'h4
`define APR_PG_R8 4'h5
`define APR_PG_R9 4'h6
`define APR_PG_R10 4'h7
`define APR_PG_R11 4'h8
`define APR_PG_R12 4'h9
`define APR_PG_R16 4'hd
`define APR_PG_R17 4'he
`define APR_PG_XI0 4'h0
`define APR_PG_XI1 4'h1
`define APR_BEEP 4
`define APR_UA_LO 3
`define APR_TWA 1
`define APR_T2 6
`define APR_T1 4
`define APR_C1OE 3
`define APR_C0OE 1
`define APR_P2SEL 5
`define APR_P0SEL 4
`define APR_AEXT 3
`define APR_ACKP 2
`define APR_PEXT 1
`define APR_PCKP 0
`define APR_KBH 6
`define APR_KBL 4
`define APR_MIPS 1
`define APR_BACKP 0
`define APR_PCKE 5
`define APR_ACKE 4
`define APR_CAP1 6
`define APR_CAP0 5
`define APR_BBCKP 2
`define APR_T3 0
`define APR_DBG 6
`define APR_UB 0
`define APR_SPI 4
`define APR_UA_HI 3
`define APR_P60 1
`define APR_PIN60_FAST_DRIVE 0
`define APR_TWB 4
`define APR_UBRX 3
`define APR_CEX 0
`define APR_AOUT 0
`define APR_IRQ1 6
`define APR_IRQ0 4
`define APR_IRQ1H 7
`define APR_IRQ0H 6
`endif

// ===== hdl/apr_pin_router.v
// Paged routing registers and the alternate-function pin multiplexer
`timescale 1ns/1ps
`include "apr_defs.vh"
// Summary of operation
// - Beeper code drives pin 4.4 with divided oscillator
// - First serial port pins from split code
// - First two-wire pins chosen by two bits
// - Timer 2 clock and control pins routed
// - Timer 1 shared pin chosen by code
// - Timer 3 clock and control pins routed
// - Comparator outputs drive pins only when enabled
// - PWM channel pairs moved by select bits
// - Counter external clock inputs pick their source
// - Counter and baud clock outputs pick pins
// - Enabled counter clock outputs toggle per overflow
// - Keypad groups of four routed by codes
// - One bit routes both master data inputs
// - Capture channels take pin or timer control
// - Debug wire taken from four source pairs
// - Second serial port pins, receive force option
// - SPI four signals mapped by two bits
// - Pin 6.0 outputs main clock, or system clock divided by 2 or 4, under RC
// - Second two-wire pins, code three shares first
// - Module I/O signals each pick one pin
// - Interrupt inputs routed by split three-bit codes
module apr_pin_router (
    input wire clk_sys,
    input wire reset_n,
    input wire [7:0] sfrAddr,
    input wire [3:0] sfrPage,
    input wire sfrWr,
    input wire sfrRd,
    input wire [7:0] sfrWrData,
    output reg [7:0] sfrRdData,
    input wire [55:0] pinIn,
    output reg [55:0] pinOut,
    output reg [55:0] pinOe,
    output wire pin60FastDrive,
    input wire sysClkIsRc,
    input wire mainClock,
    input wire lowSpeedTick,
    input wire pwmtmrOvf,
    input wire arrayOvf,
    input wire uartATx,
    input wire uartATxOe,
    output wire uartARx,
    input wire uartBTx,
    input wire uartBTxOe,
    output wire uartBRx,
    input wire twaSclLow,
    input wire twaSdaLow,
    output wire twaSclIn,
    output wire twaSdaIn,
    input wire twbSclLow,
    input wire twbSdaLow,
    output wire twbSclIn,
    output wire twbSdaIn,
    input wire tmr1Cko,
    input wire tmr1CkoOe,
    output wire tmr1In,
    input wire tmr2Cko,
    input wire tmr2CkoOe,
    output wire tmr2ClkIn,
    output wire tmr2ExIn,
    input wire tmr3Cko,
    input wire tmr3CkoOe,
    output wire tmr3ClkIn,
    output wire tmr3ExIn,
    input wire cmp0Result,
    input wire cmp1Result,
    input wire [1:0] pwmCh2Out,
    input wire [1:0] pwmCh0Out,
    input wire [1:0] pwmPairOe,
    input wire baudAClk,
    input wire baudAOe,
    input wire baudBClk,
    input wire baudBOe,
    input wire [3:0] spiOut,
    input wire [3:0] spiOe,
    output wire [3:0] spiIn,
    output wire masterIn0,
    output wire masterIn1,
    input wire [5:0] pwmModOut,
    input wire [5:0] pwmModOe,
    output wire [5:0] pwmModIn,
    input wire [1:0] arrayModOut,
    input wire [1:0] arrayModOe,
    output wire [1:0] arrayModIn,
    output wire [1:0] captureIn,
    output wire pwmtmrExtClk,
    output wire arrayExtClk,
    output wire [7:0] keypad,
    output wire irq0In,
    output wire irq1In,
    output reg debugSclIn,
    output reg debugSdaIn
);

localparam NS = 33;
integer i;
integer j;
genvar g;

// ---------------------------------------------
// Paged registers
// ---------------------------------------------
reg [7:0] aux [0:15];
reg [7:0] xi0;
reg [7:0] xi1;
wire [15:0] auxMap = `APR_AUX_PAGES;
wire auxHit = (sfrAddr == `APR_ADDR_AUX) && auxMap[sfrPage];
wire irqHit = (sfrAddr == `APR_ADDR_IRQ);

generate
    for (g = 0; g < 16; g = g + 1) begin : gReg
        localparam [3:0] PG = g;
        always @(posedge clk_sys or negedge reset_n) begin
            if (!reset_n) begin
                aux[g] <= `APR_RST;
            end else if (sfrWr && auxHit && sfrPage == PG) begin
                aux[g] <= sfrWrData;
            end
        end
    end
endgenerate

always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
        xi0 <= `APR_RST;
        xi1 <= `APR_RST;
    end else if (sfrWr && irqHit) begin
        if (sfrPage == `APR_PG_XI0) begin
            xi0 <= sfrWrData;
        end
        if (sfrPage == `APR_PG_XI1) begin
            xi1 <= sfrWrData;
        end
    end
end

always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
        sfrRdData <= 8'h00;
    end else if (sfrRd) begin
        if (auxHit) begin
            sfrRdData <= aux[sfrPage];
        end else if (irqHit && sfrPage == `APR_PG_XI0) begin
            sfrRdData <= xi0;
        end else if (irqHit && sfrPage == `APR_PG_XI1) begin
            sfrRdData <= xi1;
        end else begin
            sfrRdData <= 8'h00;
        end
    end
end

wire [7:0] r3 = aux[`APR_PG_R3];
wire [7:0] r4 = aux[`APR_PG_R4];
wire [7:0] r5 = aux[`APR_PG_R5];
wire [7:0] r6 = aux[`APR_PG_R6];
wire [7:0] r7 = aux[`APR_PG_R7];
wire [7:0] r8 = aux[`APR_PG_R8];
wire [7:0] r9 = aux[`APR_PG_R9];
wire [7:0] r10 = aux[`APR_PG_R10];
wire [7:0] r11 = aux[`APR_PG_R11];
wire [7:0] r16 = aux[`APR_PG_R16];
wire [7:0] r17 = aux[`APR_PG_R17];

wire [1:0] beeperCtrl = r3[`APR_BEEP +: 2];
wire [1:0] uartAPinsel = {r10[`APR_UA_HI], r3[`APR_UA_LO]};
wire [1:0] twowireAPinsel = r3[`APR_TWA +: 2];
wire [1:0] tmr2Pinsel = r4[`APR_T2 +: 2];
wire [1:0] tmr1Pinsel = r4[`APR_T1 +: 2];
wire [1:0] tmr3Pinsel = r8[`APR_T3 +: 2];
wire [1:0] uartBPinsel = r9[`APR_UB +: 2];
wire [1:0] twowireBPinsel = r11[`APR_TWB +: 2];
wire [1:0] spiPinsel = r10[`APR_SPI +: 2];
wire [1:0] keypadUpperSel = r6[`APR_KBH +: 2];
wire [1:0] keypadLowerSel = r6[`APR_KBL +: 2];
wire [1:0] debugWirePinsel = r9[`APR_DBG +: 2];
wire [1:0] pin60ClkoutSel = r10[`APR_P60 +: 2];
wire [2:0] irq0Pinsel = {xi1[`APR_IRQ0H], xi0[`APR_IRQ0 +: 2]};
wire [2:0] irq1Pinsel = {xi1[`APR_IRQ1H], xi0[`APR_IRQ1 +: 2]};
wire [5:0] pwmModuleOutSel = r16[`APR_CEX +: 6];
wire [1:0] arrayModuleOutSel = r17[`APR_AOUT +: 2];
assign pin60FastDrive = r10[`APR_PIN60_FAST_DRIVE];

// ---------------------------------------------
// Clock dividers
// ---------------------------------------------
reg [4:0] lsCnt;
reg [1:0] mckCnt;
reg pwmClk;
reg arrClk;
reg beepClk;
reg p60Clk;

always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
        lsCnt <= 5'h00;
        mckCnt <= 2'h0;
        pwmClk <= 1'b0;
        arrClk <= 1'b0;
    end else begin
        mckCnt <= mckCnt + 2'h1;
        if (lowSpeedTick) begin
            lsCnt <= lsCnt + 5'h01;
        end
        if (!r7[`APR_PCKE]) begin
            pwmClk <= 1'b0;
        end else if (pwmtmrOvf) begin
            pwmClk <= ~pwmClk;
        end
        if (!r7[`APR_ACKE]) begin
            arrClk <= 1'b0;
        end else if (arrayOvf) begin
            arrClk <= ~arrClk;
        end
    end
end

always @* begin
    case (beeperCtrl)
        2'h1: beepClk = lsCnt[4];
        2'h2: beepClk = lsCnt[3];
        2'h3: beepClk = lsCnt[2];
        default: beepClk = 1'b0;
    endcase
    case (pin60ClkoutSel)
        2'h1: p60Clk = mainClock;
        2'h2: p60Clk = mckCnt[0];
        2'h3: p60Clk = mckCnt[1];
        default: p60Clk = 1'b0;
    endcase
end

// ---------------------------------------------
// Pin selection tables, highest code first
// ---------------------------------------------
wire [47:0] uaTbl = {`APR_P(1,7), `APR_P(2,2), `APR_P(3,1), `APR_P(3,0),
                     `APR_P(4,4), `APR_P(4,5), `APR_P(3,0), `APR_P(3,1)};
wire [47:0] twaTbl = {`APR_P(2,2), `APR_P(2,4), `APR_P(3,1), `APR_P(3,0),
                      `APR_P(6,0), `APR_P(6,1), `APR_P(4,0), `APR_P(4,1)};
wire [47:0] t2Tbl = {`APR_P(4,5), `APR_P(4,4), `APR_P(6,0), `APR_P(3,5),
                     `APR_P(3,2), `APR_P(3,3), `APR_P(1,0), `APR_P(1,1)};
wire [23:0] t1Tbl = {`APR_P(3,3), `APR_P(1,7), `APR_P(4,5), `APR_P(3,5)};
wire [47:0] t3Tbl = {`APR_P(6,0), `APR_P(6,1), `APR_P(0,2), `APR_P(0,1),
                     `APR_P(3,3), `APR_P(3,2), `APR_P(3,3), `APR_P(3,4)};
wire [47:0] ubTbl = {`APR_P(3,4), `APR_P(3,5), `APR_P(1,0), `APR_P(1,1),
                     `APR_P(6,0), `APR_P(6,1), `APR_P(1,2), `APR_P(1,3)};
wire [47:0] twbTbl = {12'h000, `APR_P(3,0), `APR_P(3,1),
                      `APR_P(6,0), `APR_P(6,1), `APR_P(1,0), `APR_P(1,1)};
wire [95:0] spiTbl = {`APR_P(1,7), `APR_P(3,5), `APR_P(3,4), `APR_P(3,3),
                      `APR_P(3,3), `APR_P(1,5), `APR_P(1,6), `APR_P(1,7),
                      `APR_P(0,1), `APR_P(0,2), `APR_P(4,1), `APR_P(4,0),
                      `APR_P(1,4), `APR_P(1,5), `APR_P(1,6), `APR_P(1,7)};
wire [95:0] kbuTbl = {`APR_P(1,7), `APR_P(1,6), `APR_P(6,1), `APR_P(6,0),
                      `APR_P(2,6), `APR_P(2,4), `APR_P(2,3), `APR_P(2,2),
                      `APR_P(1,7), `APR_P(1,6), `APR_P(3,5), `APR_P(3,4),
                      `APR_P(1,7), `APR_P(1,6), `APR_P(1,5), `APR_P(1,4)};
wire [95:0] kblTbl = {`APR_P(4,5), `APR_P(4,4), `APR_P(4,1), `APR_P(4,0),
                      `APR_P(0,7), `APR_P(0,5), `APR_P(0,2), `APR_P(0,1),
                      `APR_P(3,3), `APR_P(3,2), `APR_P(3,1), `APR_P(3,0),
                      `APR_P(1,3), `APR_P(1,2), `APR_P(1,1), `APR_P(1,0)};
wire [47:0] irq0Tbl = {`APR_P(0,5), `APR_P(1,7), `APR_P(1,4), `APR_P(1,0),
                       `APR_P(4,0), `APR_P(3,4), `APR_P(3,0), `APR_P(3,2)};
wire [47:0] irq1Tbl = {`APR_P(0,7), `APR_P(1,0), `APR_P(1,5), `APR_P(4,5),
                       `APR_P(4,1), `APR_P(3,5), `APR_P(3,1), `APR_P(3,3)};
wire [35:0] cexA = {`APR_P(0,7), `APR_P(2,6), `APR_P(0,5),
                    `APR_P(2,4), `APR_P(2,3), `APR_P(2,2)};
wire [35:0] cexB = {`APR_P(3,5), `APR_P(3,2), `APR_P(3,4),
                    `APR_P(4,1), `APR_P(3,3), `APR_P(4,0)};

wire [11:0] uaP = uaTbl[uartAPinsel * 12 +: 12];
wire [11:0] twaP = twaTbl[twowireAPinsel * 12 +: 12];
wire [11:0] t2P = t2Tbl[tmr2Pinsel * 12 +: 12];
wire [5:0] t1P = t1Tbl[tmr1Pinsel * 6 +: 6];
wire [11:0] t3P = t3Tbl[tmr3Pinsel * 12 +: 12];
wire [11:0] ubP = ubTbl[uartBPinsel * 12 +: 12];
wire [11:0] twbP = (twowireBPinsel == 2'h3) ? twaP : twbTbl[twowireBPinsel * 12 +: 12];
wire [23:0] spiP = spiTbl[spiPinsel * 24 +: 24];
wire [23:0] kbuP = kbuTbl[keypadUpperSel * 24 +: 24];
wire [23:0] kblP = kblTbl[keypadLowerSel * 24 +: 24];
wire [5:0] pwmCkP = r5[`APR_PCKP] ? `APR_P(3,3) : `APR_P(4,7);
wire [5:0] arrCkP = r5[`APR_ACKP] ? `APR_P(3,3) : `APR_P(4,7);
wire [5:0] baCkP = r6[`APR_BACKP] ? `APR_P(4,4) : `APR_P(4,7);
wire [5:0] bbCkP = r8[`APR_BBCKP] ? `APR_P(4,5) : `APR_P(4,7);
wire [11:0] pw2P = r5[`APR_P2SEL] ? {`APR_P(3,4), `APR_P(3,5)} : {`APR_P(4,0), `APR_P(4,1)};
wire [11:0] pw0P = r5[`APR_P0SEL] ? {`APR_P(6,0), `APR_P(6,1)} : {`APR_P(1,6), `APR_P(1,7)};
wire [5:0] arr1P = arrayModuleOutSel[1] ? `APR_P(3,1) : `APR_P(6,1);
wire [5:0] arr0P = arrayModuleOutSel[0] ? `APR_P(3,0) : `APR_P(6,0);
wire [35:0] cexP;

// ---------------------------------------------
// Inputs to peripherals
// ---------------------------------------------
assign uartARx = pinIn[uaP[11:6]];
assign twaSclIn = pinIn[twaP[11:6]];
assign twaSdaIn = pinIn[twaP[5:0]];
assign twbSclIn = pinIn[twbP[11:6]];
assign twbSdaIn = pinIn[twbP[5:0]];
assign tmr2ClkIn = pinIn[t2P[11:6]];
assign tmr2ExIn = pinIn[t2P[5:0]];
assign tmr1In = pinIn[t1P];
assign tmr3ClkIn = pinIn[t3P[11:6]];
assign tmr3ExIn = pinIn[t3P[5:0]];
assign uartBRx = r11[`APR_UBRX] ? cmp0Result : pinIn[ubP[11:6]];
assign masterIn0 = r6[`APR_MIPS] ? pinIn[`APR_P(3,3)] : pinIn[`APR_P(1,6)];
assign masterIn1 = r6[`APR_MIPS] ? pinIn[`APR_P(3,5)] : pinIn[`APR_P(1,0)];
assign pwmtmrExtClk = r5[`APR_PEXT] ? pinIn[`APR_P(1,6)] : pinIn[`APR_P(0,2)];
assign arrayExtClk = r5[`APR_AEXT] ? pinIn[`APR_P(1,5)] : pwmtmrExtClk;
assign arrayModIn[1] = pinIn[arr1P];
assign arrayModIn[0] = pinIn[arr0P];
assign captureIn[1] = r8[`APR_CAP1] ? tmr2ExIn : arrayModIn[1];
assign captureIn[0] = r8[`APR_CAP0] ? tmr3ExIn : arrayModIn[0];
assign irq0In = pinIn[irq0Tbl[irq0Pinsel * 6 +: 6]];
assign irq1In = pinIn[irq1Tbl[irq1Pinsel * 6 +: 6]];

generate
    for (g = 0; g < 4; g = g + 1) begin : gQuad
        assign keypad[g] = pinIn[kblP[g * 6 +: 6]];
        assign keypad[g + 4] = pinIn[kbuP[g * 6 +: 6]];
        assign spiIn[g] = pinIn[spiP[(3 - g) * 6 +: 6]];
    end
    for (g = 0; g < 6; g = g + 1) begin : gCex
        assign cexP[g * 6 +: 6] = pwmModuleOutSel[g] ? cexB[g * 6 +: 6] : cexA[g * 6 +: 6];
        assign pwmModIn[g] = pinIn[cexP[g * 6 +: 6]];
    end
endgenerate

always @* begin
    case (debugWirePinsel)
        2'h0: begin
            debugSclIn = irq1In;
            debugSdaIn = masterIn0;
        end
        2'h1: begin
            debugSclIn = twaSclIn;
            debugSdaIn = twaSdaIn;
        end
        2'h2: begin
            debugSclIn = twbSclIn;
            debugSdaIn = twbSdaIn;
        end
        default: begin
            debugSclIn = tmr2ExIn;
            debugSdaIn = tmr3ExIn;
        end
    endcase
end

// ---------------------------------------------
// Output sources: pin, value, enable
// ---------------------------------------------
reg [5:0] sp [0:NS-1];
reg [NS-1:0] sv;
reg [NS-1:0] so;

always @* begin
    sp[0] = `APR_P(4,4);
    sv[0] = beepClk;
    so[0] = beeperCtrl != 2'h0;
    sp[1] = uaP[5:0];
    sv[1] = uartATx;
    so[1] = uartATxOe;
    sp[2] = twaP[11:6];
    sv[2] = 1'b0;
    so[2] = twaSclLow;
    sp[3] = twaP[5:0];
    sv[3] = 1'b0;
    so[3] = twaSdaLow;
    sp[4] = t2P[11:6];
    sv[4] = tmr2Cko;
    so[4] = tmr2CkoOe;
    sp[5] = t1P;
    sv[5] = tmr1Cko;
    so[5] = tmr1CkoOe;
    sp[6] = t3P[11:6];
    sv[6] = tmr3Cko;
    so[6] = tmr3CkoOe;
    sp[7] = `APR_P(0,5);
    sv[7] = cmp1Result;
    so[7] = r4[`APR_C1OE];
    sp[8] = `APR_P(4,5);
    sv[8] = cmp0Result;
    so[8] = r4[`APR_C0OE];
    sp[9] = pw2P[11:6];
    sv[9] = pwmCh2Out[0];
    so[9] = pwmPairOe[1];
    sp[10] = pw2P[5:0];
    sv[10] = pwmCh2Out[1];
    so[10] = pwmPairOe[1];
    sp[11] = pw0P[11:6];
    sv[11] = pwmCh0Out[0];
    so[11] = pwmPairOe[0];
    sp[12] = pw0P[5:0];
    sv[12] = pwmCh0Out[1];
    so[12] = pwmPairOe[0];
    sp[13] = pwmCkP;
    sv[13] = pwmClk;
    so[13] = r7[`APR_PCKE];
    sp[14] = arrCkP;
    sv[14] = arrClk;
    so[14] = r7[`APR_ACKE];
    sp[15] = baCkP;
    sv[15] = baudAClk;
    so[15] = baudAOe;
    sp[16] = bbCkP;
    sv[16] = baudBClk;
    so[16] = baudBOe;
    sp[17] = ubP[5:0];
    sv[17] = uartBTx;
    so[17] = uartBTxOe;
    for (i = 0; i < 4; i = i + 1) begin
        sp[18 + i] = spiP[(3 - i) * 6 +: 6];
        sv[18 + i] = spiOut[i];
        so[18 + i] = spiOe[i];
    end
    sp[22] = `APR_P(6,0);
    sv[22] = p60Clk;
    so[22] = sysClkIsRc && pin60ClkoutSel != 2'h0;
    sp[23] = twbP[11:6];
    sv[23] = 1'b0;
    so[23] = twbSclLow;
    sp[24] = twbP[5:0];
    sv[24] = 1'b0;
    so[24] = twbSdaLow;
    for (i = 0; i < 6; i = i + 1) begin
        sp[25 + i] = cexP[i * 6 +: 6];
        sv[25 + i] = pwmModOut[i];
        so[25 + i] = pwmModOe[i];
    end
    sp[31] = arr0P;
    sv[31] = arrayModOut[0];
    so[31] = arrayModOe[0];
    sp[32] = arr1P;
    sv[32] = arrayModOut[1];
    so[32] = arrayModOe[1];
end

// Later sources win where two claim one pin
always @* begin
    pinOut = 56'h00000000000000;
    pinOe = 56'h00000000000000;
    for (j = 0; j < NS; j = j + 1) begin
        if (so[j]) begin
            pinOut[sp[j]] = sv[j];
            pinOe[sp[j]] = 1'b1;
        end
    end
end

endmodule
